// ---- ccu_consts.svh ----
/*
 * Offsets, field positions, reset values and codes for the capture and
 * compare unit. Assumes inclusion by bare name from the unit's files.
 */
`ifndef CCU_CONSTS_SVH
`define CCU_CONSTS_SVH

// ****************************************
// Register byte addresses on APB
// ****************************************
`define ADDR_UNIT_CONTROL 12'h000
`define ADDR_VALUE_LOW 12'h004
`define ADDR_VALUE_HIGH 12'h008
`define ADDR_STATUS 12'h00c

// ****************************************
// Fields and reset values
// ****************************************
`define MODE_LSB 0
`define MODE_MSB 3
`define STATUS_FLAG_BIT 0
`define STATUS_OUT_BIT 1
`define CONTROL_RESET 8'h00

// ****************************************
// Mode codes
// ****************************************
`define MODE_OFF 4'h0
`define MODE_CMP_TOGGLE 4'h2
`define MODE_CAP_FALL 4'h4
`define MODE_CAP_RISE 4'h5
`define MODE_CAP_RISE4 4'h6
`define MODE_CAP_RISE16 4'h7
`define MODE_CMP_SET 4'h8
`define MODE_CMP_CLEAR 4'h9
`define MODE_CMP_SOFT 4'ha
`define MODE_CMP_SPECIAL 4'hb

// ****************************************
// Prescale counts
// ****************************************
`define PRESCALE_4 4'h3
`define PRESCALE_16 4'hf

`endif

// ---- ccu_pkg.sv ----
/*
 * Types shared by the capture and compare unit.
 * Assumes the consts header is compiled alongside.
 */
package ccu_pkg;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CAPTURE = 2'b01,
    ST_COMPARE = 2'b10
  } unit_state_t;

  typedef struct packed {
    logic [15:0] count;
    logic tick;
  } timer_view_t;

  typedef struct packed {
    logic timer_reset;
    logic special_trigger;
  } trigger_out_t;

endpackage

// ---- ccu_edge_scaler.sv ----
/*
 * Edge detector and prescaler for the capture input.
 * Assumes pin input is synchronous to clk.
 */
`timescale 1ns/100ps
`default_nettype none
`include "ccu_consts.svh"

module ccu_edge_scaler (
  input wire logic clk, // System clock
  input wire logic rst, // Async reset, high
  input wire logic pin_in, // Event pin level
  input wire logic [3:0] mode, // Mode field
  output logic event_pulse // Qualified capture event
);

  logic pin_prev_reg;
  logic [3:0] scale_cnt_reg;
  logic rise;
  logic fall;
  logic is_capture;

  assign rise = pin_in & ~pin_prev_reg;
  assign fall = ~pin_in & pin_prev_reg;
  assign is_capture = (mode[3:2] == 2'b01);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_prev_reg <= 1'b0;
    end else begin
      pin_prev_reg <= pin_in;
    end
  end

  // prescaler hold
  // Ratio change alone keeps the count, so a stray event can follow.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scale_cnt_reg <= 4'h0;
    end else if (!is_capture) begin
      scale_cnt_reg <= 4'h0;
    end else if (rise) begin
      scale_cnt_reg <= scale_cnt_reg + 4'h1;
    end
  end

  always_comb begin
    case (mode)
      `MODE_CAP_FALL: event_pulse = fall;
      `MODE_CAP_RISE: event_pulse = rise;
      `MODE_CAP_RISE4: event_pulse = rise && ((scale_cnt_reg & `PRESCALE_4) == `PRESCALE_4);
      `MODE_CAP_RISE16: event_pulse = rise && (scale_cnt_reg == `PRESCALE_16);
      default: event_pulse = 1'b0;
    endcase
  end

endmodule
`default_nettype wire

// ---- ccu_top.sv ----
/*
 * Capture and compare unit with APB register access.
 * Assumes a 16-bit timer outside, whose count and tick enter here and
 * which obeys the reset request; pin direction is set by port logic.
 */
// The register addresses and the APB interface to the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "ccu_consts.svh"

// Contract
// - capture timer count, set flag, overwrite
// - mode codes pick capture edge
// - compare codes toggle, set, clear output
// - mode change may raise stray flag
// - prescaler zero unless capture mode
// - any reset clears prescaler
// - ratio change keeps prescaler count
// - compare value against timer every cycle
// - mode picks single match action
// - every compare match sets flag
// - zero control write clears output latch
// - soft mode flags only, pin untouched
// - special mode resets timer, starts conversion
// - trigger at match, reset next tick
// - special reset leaves overflow flag alone
// - removed match skips timer reset
module ccu_top (
  input wire logic clk, // System clock, 100 MHz
  input wire logic rst, // Async reset, high
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire ccu_pkg::timer_view_t timer_in, // Timer count and clock tick
  input wire logic pin_in, // Event pin level
  output logic pin_out, // Compare output latch
  output logic pin_drive, // Unit controls pin
  output logic event_flag, // Unit event flag
  output ccu_pkg::trigger_out_t trig_out // Timer reset and conversion start
);

  // ****************************************
  // Registers
  // ****************************************
  logic [7:0] control_reg;
  logic [15:0] value_reg;
  logic [3:0] mode;
  logic cap_event;
  logic match;
  logic match_prev_reg;
  logic apb_access;
  logic apb_write;
  logic addr_ok;
  logic flag_clear;
  ccu_pkg::unit_state_t state;

  function automatic logic is_compare(input logic [3:0] m);
    is_compare = (m == `MODE_CMP_TOGGLE) || (m == `MODE_CMP_SET) ||
                 (m == `MODE_CMP_CLEAR) || (m == `MODE_CMP_SOFT) ||
                 (m == `MODE_CMP_SPECIAL);
  endfunction

  function automatic logic drives_pin(input logic [3:0] m);
    drives_pin = (m == `MODE_CMP_TOGGLE) || (m == `MODE_CMP_SET) ||
                 (m == `MODE_CMP_CLEAR);
  endfunction

  assign mode = control_reg[`MODE_MSB:`MODE_LSB];
  assign apb_access = psel && penable;
  assign apb_write = apb_access && pwrite;
  assign addr_ok = (paddr == `ADDR_UNIT_CONTROL) || (paddr == `ADDR_VALUE_LOW) ||
                   (paddr == `ADDR_VALUE_HIGH) || (paddr == `ADDR_STATUS);
  assign flag_clear = apb_write && (paddr == `ADDR_STATUS) &&
                      !pwdata[`STATUS_FLAG_BIT];

  always_comb begin
    if (mode[3:2] == 2'b01) begin
      state = ccu_pkg::ST_CAPTURE;
    end else if (is_compare(mode)) begin
      state = ccu_pkg::ST_COMPARE;
    end else begin
      state = ccu_pkg::ST_IDLE;
    end
  end

  ccu_edge_scaler u_scaler (
    .clk(clk),
    .rst(rst),
    .pin_in(pin_in),
    .mode(mode),
    .event_pulse(cap_event)
  );

  // ****************************************
  // APB slave
  // ****************************************
  // Zero-wait slave: ready registered in setup, high in the first cycle of the access phase.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          `ADDR_UNIT_CONTROL: prdata <= {24'h000000, control_reg};
          `ADDR_VALUE_LOW: prdata <= {24'h000000, value_reg[7:0]};
          `ADDR_VALUE_HIGH: prdata <= {24'h000000, value_reg[15:8]};
          `ADDR_STATUS: prdata <= {30'h0, pin_out, event_flag};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ****************************************
  // Control and value pair
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      control_reg <= `CONTROL_RESET;
    end else if (apb_write && pready && paddr == `ADDR_UNIT_CONTROL) begin
      control_reg <= pwdata[7:0];
    end
  end

  // capture into pair
  // A capture in the same cycle as a software write wins.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      value_reg <= 16'h0000;
    end else if (state == ccu_pkg::ST_CAPTURE && cap_event) begin
      value_reg <= timer_in.count;
    end else if (apb_write && pready && paddr == `ADDR_VALUE_LOW) begin
      value_reg[7:0] <= pwdata[7:0];
    end else if (apb_write && pready && paddr == `ADDR_VALUE_HIGH) begin
      value_reg[15:8] <= pwdata[7:0];
    end
  end

  // ****************************************
  // Compare path
  // ****************************************
  // continuous compare
  assign match = (state == ccu_pkg::ST_COMPARE) && (value_reg == timer_in.count);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      match_prev_reg <= 1'b0;
    end else begin
      match_prev_reg <= match;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      event_flag <= 1'b0;
    end else if ((state == ccu_pkg::ST_CAPTURE && cap_event) ||
                 (match && !match_prev_reg)) begin
      event_flag <= 1'b1;
    end else if (flag_clear && pready) begin
      event_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_out <= 1'b0;
    end else if (mode == `MODE_OFF) begin
      pin_out <= 1'b0;
    end else if (match && !match_prev_reg) begin
      case (mode)
        `MODE_CMP_TOGGLE: pin_out <= ~pin_out;
        `MODE_CMP_SET: pin_out <= 1'b1;
        `MODE_CMP_CLEAR: pin_out <= 1'b0;
        default: pin_out <= pin_out;
      endcase
    end
  end

  // pin control only for output modes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_drive <= 1'b0;
    end else begin
      pin_drive <= drives_pin(mode);
    end
  end

  // reset on tick
  // One process owns the whole trigger word, so each field has one driver.
  // The timer clears on its own line without raising overflow; a match
  // removed before the tick cancels the reset.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      trig_out <= '0;
    end else begin
      trig_out.special_trigger <= match && !match_prev_reg && mode == `MODE_CMP_SPECIAL;
      trig_out.timer_reset <= match && mode == `MODE_CMP_SPECIAL && timer_in.tick &&
                              !trig_out.timer_reset;
    end
  end

endmodule
`default_nettype wire

// ---- ccu_top_chk.sv ----
/* Port assertions for the capture and compare unit.
   Assumes binding into ccu_top, one clock, async high reset. */
`timescale 1ns/100ps
`default_nettype none
module ccu_top_chk (
  input wire logic clk, // Clock
  input wire logic rst, // Reset
  input wire logic psel, // Select
  input wire logic penable, // Enable
  input wire logic pwrite, // Direction
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire ccu_pkg::timer_view_t timer_in, // Timer view
  input wire logic pin_out, // Output latch
  input wire logic pin_drive, // Pin control
  input wire logic event_flag, // Event flag
  input wire ccu_pkg::trigger_out_t trig_out // Triggers
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held past one cycle");
  a_err_access: assert property (pslverr |-> pready && psel && penable)
    else $error("pslverr outside an access");
  a_trig_pulse: assert property (
    trig_out.special_trigger |=> !trig_out.special_trigger)
    else $error("trigger longer than one cycle");
  a_trig_flag: assert property (trig_out.special_trigger |-> event_flag)
    else $error("trigger without flag");
  a_trig_nodrive: assert property (trig_out.special_trigger |-> !pin_drive)
    else $error("pin driven in trigger mode");
  a_reset_tick: assert property (
    trig_out.timer_reset |-> $past(timer_in.tick) && !pin_drive)
    else $error("timer reset without tick");
  a_out_rise: assert property ($rose(pin_out) |-> pin_drive && event_flag)
    else $error("latch rose without match action");
  a_flag_swclear: assert property (
    $fell(event_flag) |-> $past(psel && penable && pwrite && pready))
    else $error("flag fell without a write");
  c_trig: cover property (trig_out.special_trigger);
  c_treset: cover property (trig_out.timer_reset);
  c_out: cover property ($rose(pin_out));
endmodule
bind ccu_top ccu_top_chk chk (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .timer_in(timer_in),
  .pin_out(pin_out), .pin_drive(pin_drive), .event_flag(event_flag), .trig_out(trig_out));
`default_nettype wire

// ---- ccu_timer_model.sv ----
/* Behavioural 16-bit timer feeding the unit.
   Assumes the unit's reset request arrives as a one-cycle pulse. */
`timescale 1ns/100ps
`default_nettype none
module ccu_timer_model (
  input wire logic clk, // System clock
  input wire logic rst, // Async reset, high
  input wire logic run, // Count enable
  input wire ccu_pkg::trigger_out_t trig_in, // Requests from unit
  output ccu_pkg::timer_view_t tv, // Count and tick
  output logic ovf_flag // Own overflow flag
);
  // ****************************************
  // Counter
  // ****************************************
  logic phase_reg;
  logic [15:0] count_reg;
  assign tv = {count_reg, phase_reg & run};
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase_reg <= 1'b0;
      count_reg <= 16'h0000;
      ovf_flag <= 1'b0;
    end else begin
      phase_reg <= ~phase_reg;
      if (trig_in.timer_reset) count_reg <= 16'h0000;
      else if (tv.tick) begin
        count_reg <= count_reg + 16'h0001;
        if (count_reg == 16'hffff) ovf_flag <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- timer_capture_compare_unit_test.sv ----
/* Self-checking bench for the capture and compare unit.
   Assumes ccu_top, the timer model and the bound checker. */
`timescale 1ns/100ps
`default_nettype none
`include "ccu_consts.svh"
module timer_capture_compare_unit_test;
  // ****************************************
  // Signals and tasks
  // ****************************************
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic pin_in = 1'b0, run = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, seed = 32'h000177e5;
  logic pready, pslverr, pin_out, pin_drive, event_flag;
  ccu_pkg::timer_view_t tv;
  ccu_pkg::trigger_out_t trig;
  logic [32:0] exp_q[$];
  logic [32:0] e_note;
  logic [15:0] cnt;
  logic [3:0] cm [6] = '{4'h8, 4'h2, 4'h2, 4'h9, 4'h8, 4'ha};
  logic cv [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
  int np [4] = '{1, 1, 4, 16};
  int fail_count = 0;
  int n_tests = 0;
  always #5 clk = ~clk;
  ccu_top uut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_in(tv), .pin_in(pin_in), .pin_out(pin_out), .pin_drive(pin_drive),
    .event_flag(event_flag), .trig_out(trig));
  ccu_timer_model tm (.clk(clk), .rst(rst), .run(run), .trig_in(trig), .tv(tv), .ovf_flag());
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic end_of_test();
    if (fail_count == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic miss(input string m);
    fail_count++;
    $display("MISMATCH %0t %s", $time, m);
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) miss("port value");
  endtask
  task automatic cmp_apb(input logic [32:0] e);
    n_tests++;
    if (pslverr !== e[32] || (!pwrite && prdata !== e[31:0])) miss("apb answer");
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
    input logic [32:0] e);
    exp_q.push_back(e);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] d);
    apb(1'b0, a, 32'h0, {1'b0, d});
  endtask
  // Pulses long enough for any sync delay
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge clk) pin_in <= 1'b1;
      repeat (3) @(posedge clk);
      pin_in <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask
  always @(posedge clk) begin
    if (psel && penable && pready) begin
      e_note = exp_q.pop_front();
      cmp_apb(e_note);
    end
  end
  initial begin
    #100000;
    miss("timeout");
    end_of_test();
  end
  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd(`ADDR_UNIT_CONTROL, 32'h0);
    apb(1'b0, 12'h010, 32'h0, {1'b1, 32'h0});
    for (int i = 0; i < 4; i++) begin
      run <= 1'b1;
      repeat (rnd() % 40 + 1) @(posedge clk);
      run <= 1'b0;
      wr(`ADDR_UNIT_CONTROL, 32'h0);
      wr(`ADDR_UNIT_CONTROL, 32'h4 + i);
      wr(`ADDR_STATUS, 32'h0);
      pulse(np[i] - 1);
      rd(`ADDR_STATUS, 32'h0);
      pulse(1);
      cnt = tv.count;
      rd(`ADDR_STATUS, 32'h1);
      rd(`ADDR_VALUE_LOW, {24'h0, cnt[7:0]});
      rd(`ADDR_VALUE_HIGH, {24'h0, cnt[15:8]});
    end
    wr(`ADDR_UNIT_CONTROL, 32'h0);
    wr(`ADDR_VALUE_HIGH, {24'h0, cnt[15:8]});
    // pin held quiet as an output
    for (int i = 0; i < 6; i++) begin
      wr(`ADDR_VALUE_LOW, {24'h0, cnt[7:0] ^ 8'h01});
      wr(`ADDR_UNIT_CONTROL, {28'h0, cm[i]});
      wr(`ADDR_STATUS, 32'h0);
      wr(`ADDR_VALUE_LOW, {24'h0, cnt[7:0]});
      rd(`ADDR_STATUS, {30'h0, cv[i], 1'b1});
      cmp_bit(pin_out, cv[i]);
      cmp_bit(event_flag, 1'b1);
      cmp_bit(pin_drive, cm[i] != `MODE_CMP_SOFT);
    end
    cmp_bit(pin_drive, 1'b0);
    wr(`ADDR_UNIT_CONTROL, 32'h0);
    rd(`ADDR_STATUS, 32'h1);
    cnt = cnt + 16'h0010;
    wr(`ADDR_VALUE_HIGH, {24'h0, cnt[15:8]});
    wr(`ADDR_VALUE_LOW, {24'h0, cnt[7:0]});
    wr(`ADDR_STATUS, 32'h0);
    wr(`ADDR_UNIT_CONTROL, 32'hb);
    run <= 1'b1;
    for (int i = 0; i < 200 && trig.special_trigger !== 1'b1; i++) @(negedge clk);
    cmp_bit(trig.special_trigger, 1'b1);
    cmp_bit(pin_drive, 1'b0);
    for (int i = 0; i < 20 && tv.count !== 16'h0000; i++) @(negedge clk);
    cmp_bit(tv.count == 16'h0000, 1'b1);
    rd(`ADDR_STATUS, 32'h1);
    end_of_test();
  end
endmodule
`default_nettype wire
